// >>> emu_map_params.svh
// constants of the emulation memory map: offsets, fields, counts
// assumes a 40 MHz core clock and a 20-bit program address space
`ifndef EMU_MAP_PARAMS_SVH
`define EMU_MAP_PARAMS_SVH
`define CLK_PERIOD_NS    25
`define ADDR_W           20
`define DATA_W           16
`define BLK_SHIFT        10
`define NUM_BLKS         1024
`define CHASSIS_GRAN     16
`define PROBE_CAP_BLKS   32
`define CHASSIS_BRD_BLKS 128
`define CHASSIS_BOARDS   2
`define USER_SYNC_NS     75
`define USER_WAIT_CYC    ((`USER_SYNC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_WAIT_CYC    1
`define REG_START        8'h00
`define REG_END          8'h04
`define REG_CTRL         8'h08
`define REG_STATUS       8'h0C
`define CTRL_TGT_LSB     0
`define CTRL_GUARD_BIT   2
`define CTRL_RO_BIT      3
`define CTRL_WO_BIT      4
`define CTRL_TAG_LSB     5
`define CTRL_TAGEN_BIT   8
`define CTRL_RESET_BIT   30
`define CTRL_GO_BIT      31
`define ST_BUSY          0
`define ST_ERR_CAP       1
`define ST_ERR_OVL       2
`define ST_ERR_EXP       3
`define ST_ERR_ALN       4
`define ST_ERR_TAG       5
`define ST_WIDENED       6
`define ST_VFY_FAIL      7
`define ST_HOST_REF      8
`define ST_BRK_PEND      9
`endif

// >>> emu_map_pkg.sv
// types of the emulation memory map
// assumes emu_map_params.svh alongside
`include "emu_map_params.svh"
package emu_map_pkg;
    typedef enum logic [1:0] {
        TGT_USER    = 2'b00,
        TGT_PROBE   = 2'b01,
        TGT_CHASSIS = 2'b10,
        TGT_EXPBUS  = 2'b11
    } tgt_t;
    typedef struct packed {
        tgt_t       tgt;
        logic       ro;
        logic       wo;
        logic [2:0] tag;
    } entry_t;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic               write;
        logic [`DATA_W-1:0] wdata;
        logic               host;
    } acc_req_t;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_SCAN = 2'b01, M_WRITE = 2'b10
    } map_st_t;
    typedef enum logic [1:0] {
        A_IDLE = 2'b00, A_WAIT = 2'b01, A_DONE = 2'b10
    } acc_st_t;
endpackage

// >>> emulation_memory_map.sv
// emulation memory map: per-block target and protection for the probe bus
// assumes probe bus requests on core_clk; prototype and expansion pins async
// Operation
// - probe memory mapped in 1K blocks
// - chassis memory in aligned 16K blocks
// - all blocks guarded after initialisation
// - guarded access completes, break after instruction
// - read-only write performed, then break
// - write-only blocks skip verification reads
// - host writes are read back and compared
// - prototype gets strobes and write data on every access that is not refused
// - prototype read data used only for user
// - 32K probe memory, no overlap allowed
// - wait states while expansion bus arbitrates
// - shared expansion areas by tag, equal sizes
// - partial expansion remap rejected with error
// - off-boundary range widened and reported
// - over-capacity request rejected, map unchanged
// - chassis overlap boundary must be 16K aligned
// - host access to guarded block refused
// - map reset guards every block at once
// - lock honoured: expansion held, prototype lock
// - two 128K chassis boards, zero wait (the design gives chassis blocks FAST_WAIT_CYC = 1 wait cycle)
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`include "emu_map_params.svh"
module emulation_memory_map (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // probe processor bus
    input  wire emu_map_pkg::acc_req_t acc_req,
    input  wire logic                 acc_start,
    input  wire logic                 bus_lock,
    input  wire logic                 instr_done,
    output logic                      acc_ack,
    output logic                      acc_refused,
    output logic      [`DATA_W-1:0]   acc_rdata,
    output logic                      emu_break,
    // prototype pins
    input  wire logic [`DATA_W-1:0]   proto_rdata,
    output logic                      proto_rd,
    output logic                      proto_wr,
    output logic      [`DATA_W-1:0]   proto_wdata,
    output logic                      proto_lock,
    // fast memories and expansion bus
    input  wire logic [`DATA_W-1:0]   mem_rdata,
    output logic      [1:0]           mem_sel,
    output logic                      mem_wr,
    input  wire logic                 exp_gnt,
    input  wire logic [`DATA_W-1:0]   exp_rdata,
    output logic                      exp_req
);
    import emu_map_pkg::*;

    // ----------------------------------------
    // map storage
    // ----------------------------------------
    // valid low means guarded; one vector clear resets the whole map
    entry_t        map_mem [`NUM_BLKS];
    logic [`NUM_BLKS-1:0] blk_valid;
    logic [10:0]   tag_len [8];
    logic [7:0]    tag_used;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [`ADDR_W-1:0] reg_start, reg_end;
    logic [31:0]        reg_ctrl;
    logic [9:0]         stat_err;
    map_st_t            map_st;
    logic [9:0]         scan_i;
    logic [9:0]         sb, eb;
    logic [10:0]        n_probe, n_chas, n_exp_all, n_exp_in;
    logic               ovl_err, aln_err;
    logic               vfy_bad, brk_pend;
    wire wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr    = wb_hit & wb_we_i & (&wb_sel_i);
    wire go_wr    = wb_wr & (wb_adr_i == `REG_CTRL) & wb_dat_i[`CTRL_GO_BIT];
    wire rst_wr   = wb_wr & (wb_adr_i == `REG_CTRL) & wb_dat_i[`CTRL_RESET_BIT];
    wire busy     = (map_st != M_IDLE);
    wire [31:0] status_word = {22'h0, stat_err[9:1], busy};
    wire [31:0] rd_mux =
        (wb_adr_i == `REG_START)  ? {12'h0, reg_start} :
        (wb_adr_i == `REG_END)    ? {12'h0, reg_end} :
        (wb_adr_i == `REG_CTRL)   ? reg_ctrl :
        (wb_adr_i == `REG_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
            reg_start <= '0;
            reg_end   <= '0;
            reg_ctrl  <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0000_0000;
            if (wb_wr && !busy && wb_adr_i == `REG_START) reg_start <= wb_dat_i[`ADDR_W-1:0];
            if (wb_wr && !busy && wb_adr_i == `REG_END)   reg_end   <= wb_dat_i[`ADDR_W-1:0];
            if (wb_wr && !busy && wb_adr_i == `REG_CTRL)  reg_ctrl  <= {2'b00, wb_dat_i[29:0]};
        end
    end

    // ----------------------------------------
    // map request decode
    // ----------------------------------------
    tgt_t        c_tgt;
    assign c_tgt = tgt_t'(reg_ctrl[`CTRL_TGT_LSB +: 2]);
    wire       c_guard = reg_ctrl[`CTRL_GUARD_BIT];
    wire [2:0] c_tag   = reg_ctrl[`CTRL_TAG_LSB +: 3];
    wire       c_tagen = reg_ctrl[`CTRL_TAGEN_BIT] & (c_tgt == TGT_EXPBUS);
    wire [9:0] raw_sb  = reg_start[`ADDR_W-1:`BLK_SHIFT];
    wire [9:0] raw_eb  = reg_end[`ADDR_W-1:`BLK_SHIFT];
    // chassis widened to 16K
    // from the go word itself: reg_ctrl still holds the old command here
    wire       chas    = ~wb_dat_i[`CTRL_GUARD_BIT] &
                         (wb_dat_i[`CTRL_TGT_LSB +: 2] == TGT_CHASSIS);
    wire [9:0] w_sb    = chas ? {raw_sb[9:4], 4'h0} : raw_sb;
    wire [9:0] w_eb    = chas ? {raw_eb[9:4], 4'hF} : raw_eb;
    wire       widen   = (reg_start[`BLK_SHIFT-1:0] != '0) |
                         (&reg_end[`BLK_SHIFT-1:0] == 1'b0) |
                         (w_sb != raw_sb) | (w_eb != raw_eb);
    wire [10:0] req_n  = {1'b0, eb} - {1'b0, sb} + 11'd1;
    entry_t    scan_e;
    assign scan_e = map_mem[scan_i];
    wire       in_rng  = (scan_i >= sb) & (scan_i <= eb);
    wire       s_val   = blk_valid[scan_i];
    wire err_cap = ~c_guard &
        (((c_tgt == TGT_PROBE) & (n_probe + req_n > 11'(`PROBE_CAP_BLKS))) |
         ((c_tgt == TGT_CHASSIS) &
          (n_chas + req_n > 11'(`CHASSIS_BRD_BLKS * `CHASSIS_BOARDS))));
    // expansion area changes whole or not at all
    wire err_exp = (n_exp_in != 11'd0) & (n_exp_in != n_exp_all);
    wire err_tag = c_tagen & tag_used[c_tag] & (tag_len[c_tag] != req_n);
    wire any_err = err_cap | err_exp | err_tag | ovl_err | aln_err;

    // ----------------------------------------
    // map engine: one scan of all blocks, then write
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            map_st    <= M_IDLE;
            scan_i    <= '0;
            sb        <= '0;
            eb        <= '0;
            n_probe   <= '0;
            n_chas    <= '0;
            n_exp_all <= '0;
            n_exp_in  <= '0;
            ovl_err   <= 1'b0;
            aln_err   <= 1'b0;
            tag_used  <= 8'h00;
        end else begin
            case (map_st)
                M_IDLE: begin
                    if (rst_wr) begin
                        tag_used <= 8'h00;
                    end else if (go_wr) begin
                        map_st  <= M_SCAN;
                        scan_i  <= '0;
                        sb      <= w_sb;
                        eb      <= w_eb;
                        n_probe <= '0;
                        n_chas  <= '0;
                        n_exp_all <= '0;
                        n_exp_in  <= '0;
                        ovl_err <= 1'b0;
                        aln_err <= 1'b0;
                    end
                end
                M_SCAN: begin
                    if (s_val && !in_rng && scan_e.tgt == TGT_PROBE)   n_probe <= n_probe + 11'd1;
                    if (s_val && !in_rng && scan_e.tgt == TGT_CHASSIS) n_chas <= n_chas + 11'd1;
                    if (s_val && scan_e.tgt == TGT_EXPBUS)  n_exp_all <= n_exp_all + 11'd1;
                    if (s_val && scan_e.tgt == TGT_EXPBUS && in_rng) n_exp_in <= n_exp_in + 11'd1;
                    // probe memory may not overlap others
                    if (s_val && in_rng && c_tgt == TGT_PROBE && !c_guard &&
                        scan_e.tgt != TGT_PROBE) ovl_err <= 1'b1;
                    if (s_val && scan_e.tgt == TGT_CHASSIS &&
                        ((scan_i == sb && sb[3:0] != 4'h0) ||
                         (scan_i == eb && eb[3:0] != 4'hF))) aln_err <= 1'b1;
                    scan_i <= scan_i + 10'd1;
                    if (&scan_i) begin
                        map_st <= M_WRITE;
                        scan_i <= sb;
                    end
                end
                M_WRITE: begin
                    // any error leaves the map untouched
                    if (any_err || scan_i == eb) map_st <= M_IDLE;
                    scan_i <= scan_i + 10'd1;
                    if (!any_err && c_tagen && scan_i == eb) tag_used[c_tag] <= 1'b1;
                end
                default: map_st <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (map_st == M_WRITE && !any_err) begin
            map_mem[scan_i] <= '{tgt: c_tgt, ro: reg_ctrl[`CTRL_RO_BIT],
                                 wo: reg_ctrl[`CTRL_WO_BIT], tag: c_tag};
        end
        if (map_st == M_WRITE && !any_err && c_tagen && scan_i == eb) tag_len[c_tag] <= req_n;
    end

    always_ff @(posedge core_clk) begin
        if (rst || (rst_wr && !busy)) begin
            blk_valid <= '0;
        end else if (map_st == M_WRITE && !any_err) begin
            blk_valid[scan_i] <= ~c_guard;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_err <= '0;
        end else begin
            if (go_wr && !busy) stat_err[`ST_WIDENED:`ST_ERR_CAP] <= {widen, 5'b0};
            if (map_st == M_WRITE && scan_i == sb) begin
                stat_err[`ST_ERR_TAG:`ST_ERR_CAP] <=
                    {err_tag, aln_err, err_exp, ovl_err, err_cap};
            end
            if (acc_ack) stat_err[`ST_VFY_FAIL] <= vfy_bad;
            if (acc_refused) stat_err[`ST_HOST_REF] <= 1'b1;
            else if (go_wr) stat_err[`ST_HOST_REF] <= 1'b0;
            stat_err[`ST_BRK_PEND] <= brk_pend;
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`DATA_W-1:0] pr_s1, pr_s2, ex_s1, ex_s2;
    logic               gnt_s1, gnt_s2;
    always_ff @(posedge core_clk) begin
        pr_s1  <= proto_rdata;
        pr_s2  <= pr_s1;
        ex_s1  <= exp_rdata;
        ex_s2  <= ex_s1;
        gnt_s1 <= exp_gnt;
        gnt_s2 <= gnt_s1;
    end

    // ----------------------------------------
    // access path
    // ----------------------------------------
    // lookup on each bus cycle
    entry_t   lk_e;
    assign lk_e = map_mem[acc_req.addr[`ADDR_W-1:`BLK_SHIFT]];
    wire      lk_val = blk_valid[acc_req.addr[`ADDR_W-1:`BLK_SHIFT]];
    acc_st_t  acc_st;
    acc_req_t cur;
    entry_t   cur_e;
    logic     cur_val, vfy;
    logic [2:0] wait_cnt;
    wire      refuse = acc_start & acc_req.host & ~lk_val;
    // chassis and probe get FAST_WAIT_CYC wait cycles, user blocks USER_WAIT_CYC
    wire [2:0] wait_len = (lk_val && lk_e.tgt != TGT_USER) ? 3'(`FAST_WAIT_CYC)
                                                          : 3'(`USER_WAIT_CYC);
    wire      is_exp = cur_val & (cur_e.tgt == TGT_EXPBUS);
    wire      wait_over = is_exp ? gnt_s2 : (wait_cnt == 3'd0);
    // prototype data only for user blocks
    wire [`DATA_W-1:0] rd_src = (!cur_val || cur_e.tgt == TGT_USER) ? pr_s2 :
                                is_exp ? ex_s2 : mem_rdata;
    wire      need_vfy = cur.write & cur.host & ~vfy & ~(cur_val & cur_e.wo);
    wire      brk_hit = acc_start & ~acc_req.host &
                        (~lk_val | (acc_req.write & lk_e.ro));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_st      <= A_IDLE;
            cur         <= '0;
            cur_e       <= '0;
            cur_val     <= 1'b0;
            vfy         <= 1'b0;
            vfy_bad     <= 1'b0;
            wait_cnt    <= '0;
            acc_ack     <= 1'b0;
            acc_refused <= 1'b0;
            acc_rdata   <= '0;
            proto_rd    <= 1'b0;
            proto_wr    <= 1'b0;
            proto_wdata <= '0;
            mem_sel     <= 2'b00;
            mem_wr      <= 1'b0;
            exp_req     <= 1'b0;
        end else begin
            acc_ack     <= 1'b0;
            acc_refused <= 1'b0;
            proto_rd    <= 1'b0;
            proto_wr    <= 1'b0;
            mem_wr      <= 1'b0;
            case (acc_st)
                A_IDLE: begin
                    if (refuse) begin
                        acc_refused <= 1'b1;
                    end else if (acc_start) begin
                        acc_st   <= A_WAIT;
                        cur      <= acc_req;
                        cur_e    <= lk_e;
                        cur_val  <= lk_val;
                        vfy      <= 1'b0;
                        vfy_bad  <= 1'b0;
                        wait_cnt <= wait_len;
                        proto_rd    <= ~acc_req.write;
                        proto_wr    <= acc_req.write;
                        proto_wdata <= acc_req.wdata;
                        mem_sel     <= lk_val ? lk_e.tgt : TGT_USER;
                        mem_wr      <= acc_req.write;
                        exp_req     <= lk_val & (lk_e.tgt == TGT_EXPBUS);
                    end
                end
                A_WAIT: begin
                    if (wait_cnt != 3'd0) wait_cnt <= wait_cnt - 3'd1;
                    if (wait_over) begin
                        // locked cycles keep the expansion bus
                        exp_req <= bus_lock & is_exp;
                        if (need_vfy) begin
                            vfy      <= 1'b1;
                            wait_cnt <= (cur_val && cur_e.tgt != TGT_USER) ?
                                        3'(`FAST_WAIT_CYC) : 3'(`USER_WAIT_CYC);
                            proto_rd <= 1'b1;
                            exp_req  <= is_exp;
                        end else begin
                            acc_st  <= A_DONE;
                            acc_ack <= 1'b1;
                            acc_rdata <= rd_src;
                            vfy_bad <= vfy & (rd_src != cur.wdata);
                        end
                    end
                end
                A_DONE: begin
                    acc_st  <= A_IDLE;
                    mem_sel <= 2'b00;
                end
                default: acc_st <= A_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            brk_pend  <= 1'b0;
            emu_break <= 1'b0;
        end else begin
            emu_break <= instr_done & (brk_pend | brk_hit);
            brk_pend  <= brk_hit | (brk_pend & ~instr_done);
        end
    end

    // prototype lock only for user blocks
    always_ff @(posedge core_clk) begin
        if (rst) proto_lock <= 1'b0;
        else     proto_lock <= bus_lock & acc_start & (~lk_val | lk_e.tgt == TGT_USER);
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_break_after_guard;
        @(posedge core_clk) disable iff (rst)
        (acc_start && !acc_req.host && !lk_val) |=> brk_pend;
    endproperty
    a_break_after_guard: assert property (p_break_after_guard)
        else $error("guarded access gave no break");

    property p_break_on_done;
        @(posedge core_clk) disable iff (rst)
        (brk_pend && instr_done) |=> emu_break;
    endproperty
    a_break_on_done: assert property (p_break_on_done)
        else $error("pending break not raised at instruction end");

    property p_ro_break;
        @(posedge core_clk) disable iff (rst)
        (acc_start && !acc_req.host && lk_val && lk_e.ro && acc_req.write) |=> brk_pend;
    endproperty
    a_ro_break: assert property (p_ro_break)
        else $error("read-only write gave no break");

    property p_strobe;
        @(posedge core_clk) disable iff (rst)
        (acc_start && !refuse && acc_st == A_IDLE) |=>
            (proto_wr == $past(acc_req.write)) && (proto_rd != proto_wr);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("prototype strobe missing");

    property p_refuse;
        @(posedge core_clk) disable iff (rst)
        (acc_st == A_IDLE && acc_start && acc_req.host && !lk_val) |=>
            acc_refused && !proto_rd && !proto_wr;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("guarded host access not refused");

    property p_map_reset;
        @(posedge core_clk) disable iff (rst)
        (rst_wr && !busy) |=> (blk_valid == '0);
    endproperty
    a_map_reset: assert property (p_map_reset)
        else $error("map reset left a block mapped");

    property p_exp_wait;
        @(posedge core_clk) disable iff (rst)
        (acc_st == A_WAIT && is_exp && !gnt_s2) |=> !acc_ack;
    endproperty
    a_exp_wait: assert property (p_exp_wait)
        else $error("expansion access ended before grant");

    property p_lock_user;
        @(posedge core_clk) disable iff (rst)
        (acc_start && lk_val && lk_e.tgt != TGT_USER) |=> !proto_lock;
    endproperty
    a_lock_user: assert property (p_lock_user)
        else $error("prototype lock on non-user block");

    property p_no_vfy_wo;
        @(posedge core_clk) disable iff (rst)
        (acc_st == A_WAIT && cur_val && cur_e.wo && wait_over) |=> !vfy;
    endproperty
    a_no_vfy_wo: assert property (p_no_vfy_wo)
        else $error("verify read on write-only block");

    property p_err_nochange;
        @(posedge core_clk) disable iff (rst)
        (map_st == M_WRITE && any_err) |=> $stable(blk_valid);
    endproperty
    a_err_nochange: assert property (p_err_nochange)
        else $error("rejected map request changed the map");

    c_vfy:   cover property (@(posedge core_clk) vfy && acc_ack);
    c_brk:   cover property (@(posedge core_clk) emu_break);
    c_exp:   cover property (@(posedge core_clk) is_exp && acc_ack);
    c_error: cover property (@(posedge core_clk) map_st == M_WRITE && any_err);
endmodule

// >>> emu_partner.sv
// far side: prototype memory, fast memories and expansion bus grant
// assumes the device's registered selects and requests on core_clk
`timescale 1ns/10ps
module emu_partner (
    // clock
    input  wire logic        core_clk,
    // device side
    input  wire logic [1:0]  mem_sel,
    input  wire logic        exp_req,
    // answers
    output logic      [15:0] proto_rdata,
    output logic      [15:0] mem_rdata,
    output logic             exp_gnt,
    output logic      [15:0] exp_rdata
);
    logic [15:0] toggle  = 16'h0000;
    logic [1:0]  gnt_dly = 2'b00;
    // idle fast-memory and expansion data lines flip every cycle so a stale value never matches; prototype data stays C3C3
    always @(posedge core_clk) begin
        toggle  <= ~toggle;
        gnt_dly <= {gnt_dly[0], exp_req};
    end
    assign proto_rdata = 16'hC3C3;
    assign mem_rdata   = (mem_sel != 2'b00) ? 16'h1234 : toggle;
    assign exp_gnt     = gnt_dly[1];
    assign exp_rdata   = exp_gnt ? 16'h0E0E : toggle;
endmodule

// >>> emulation_memory_map_tb_top.sv
// bench for the emulation memory map: wishbone map commands, probe accesses
// assumes emu_partner on the far side and design assertions inside the dut
`timescale 1ns/10ps
`include "emu_map_params.svh"
module emulation_memory_map_tb_top;
    import emu_map_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, start = 1'b0, done = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdo, q, st;
    acc_req_t req = '0;
    logic aack, aref, brk, prd, pwr, plock, mwr, gnt, xreq, sw, sr;
    logic [15:0] ard, pwd, prdata, mrd, xrd;
    logic [1:0] msel, ms;
    int n_fail = 0, checks_done = 0;
    always #12.5 core_clk = ~core_clk;
    emulation_memory_map i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdo),
        .wb_ack_o(ack), .acc_req(req), .acc_start(start), .bus_lock(1'b0), .instr_done(done),
        .acc_ack(aack), .acc_refused(aref), .acc_rdata(ard), .emu_break(brk),
        .proto_rdata(prdata), .proto_rd(prd), .proto_wr(pwr), .proto_wdata(pwd),
        .proto_lock(plock), .mem_rdata(mrd), .mem_sel(msel), .mem_wr(mwr), .exp_gnt(gnt),
        .exp_rdata(xrd), .exp_req(xreq));
    emu_partner i_far (.core_clk(core_clk), .mem_sel(msel), .exp_req(xreq),
        .proto_rdata(prdata), .mem_rdata(mrd), .exp_gnt(gnt), .exp_rdata(xrd));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ---------------------------------------------
    // bus cycles
    // ---------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge core_clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdo;
        cyc <= 1'b0;
        @(posedge core_clk);
        if (i >= 20) begin
            n_fail++;
            end_sim();
        end
    endtask
    // go command, then poll until the scan and the write finish
    task automatic map(input logic [31:0] s, input logic [31:0] e, input logic [31:0] c);
        int i;
        i = 0;
        wb(1'b1, `REG_START, s);
        wb(1'b1, `REG_END, e);
        wb(1'b1, `REG_CTRL, c | 32'h8000_0000);
        do begin
            wb(1'b0, `REG_STATUS, 32'h0000_0000);
            i++;
        end while (q[0] !== 1'b0 && i < 2000);
        st = q;
        if (i >= 2000) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic acc(input logic [19:0] a, input logic w, input logic h);
        int i;
        i = 0;
        sw = 1'b0;
        sr = 1'b0;
        req   <= '{addr: a, write: w, wdata: 16'h5AA5, host: h};
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        do begin
            @(posedge core_clk);
            i++;
            sw = sw | (pwr === 1'b1) | (prd === 1'b1);
            if (i == 2) ms = msel;
        end while (aack !== 1'b1 && aref !== 1'b1 && i < 60);
        sr = (aref === 1'b1);
        if (i >= 60) begin
            n_fail++;
            end_sim();
        end
    endtask
    // break comes one cycle after the instruction ends; allow one spare
    task automatic brk_chk(input logic e);
        logic b;
        done <= 1'b1;
        @(posedge core_clk);
        done <= 1'b0;
        @(posedge core_clk);
        b = brk;
        @(posedge core_clk);
        chk(b | brk, e);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        wb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        acc(20'h0_0400, 1'b0, 1'b0);
        chk({sr, sw, ard}, {2'b01, 16'hC3C3});
        brk_chk(1'b1);
        acc(20'h0_0400, 1'b0, 1'b1);
        chk(sr, 1'b1);
        $display("test guarded done");
        map(32'h0000_0000, 32'h0000_03FF, 32'h0000_0001);
        chk(st & 32'h0000_007E, 32'h0000_0000);
        acc(20'h0_0000, 1'b0, 1'b0);
        chk({sw, ms, ard}, {1'b1, 2'b01, 16'h1234});
        brk_chk(1'b0);
        map(32'h0000_0800, 32'h0000_0FFF, 32'h0000_0008);
        acc(20'h0_0800, 1'b1, 1'b0);
        chk({sw, ms}, {1'b1, 2'b00});
        brk_chk(1'b1);
        acc(20'h0_0000, 1'b1, 1'b1);
        wb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk(q[`ST_VFY_FAIL], 1'b1);
        map(32'h0000_1000, 32'h0000_13FF, 32'h0000_0010);
        acc(20'h0_1000, 1'b1, 1'b1);
        wb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk(q[`ST_VFY_FAIL], 1'b0);
        map(32'h0000_2000, 32'h0000_27FF, 32'h0000_0003);
        acc(20'h0_2000, 1'b0, 1'b0);
        chk({ms, ard}, {2'b11, 16'h0E0E});
        map(32'h0000_2400, 32'h0000_27FF, 32'h0000_0000);
        chk(st[`ST_ERR_EXP], 1'b1);
        map(32'h0000_0800, 32'h0000_0BFF, 32'h0000_0001);
        chk(st[`ST_ERR_OVL], 1'b1);
        $display("test mapped done");
        map(32'h0000_0010, 32'h0000_01F0, 32'h0000_0001);
        chk(st[`ST_WIDENED], 1'b1);
        map(32'h0000_0000, 32'h000F_FFFF, 32'h0000_0001);
        chk(st[`ST_ERR_CAP], 1'b1);
        acc(20'h0_0400, 1'b0, 1'b0);
        brk_chk(1'b1);
        wb(1'b1, `REG_CTRL, 32'h4000_0000);
        repeat (4) @(posedge core_clk);
        acc(20'h0_0000, 1'b0, 1'b0);
        chk(ms, 2'b00);
        brk_chk(1'b1);
        $display("test errors done");
        end_sim();
    end
endmodule
